//--- rtl/smx_submixer.sv
// Purpose: sixteen output submixers with gain, dither, mute, meter, routing
// Assumes: record and play buses stable around the word clock rising edge
// Notes: one frame is computed per word clock rising edge
`timescale 1ns/1ps
`default_nettype none
module smx_submixer
  import smx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_clk_i,
  input wire logic [SMX_CH*SMX_SW-1:0] record_bus_i,
  input wire logic [SMX_CH*SMX_SW-1:0] play_bus_i,
  input wire logic [SMX_AW-1:0] reg_addr_i,
  input wire logic [SMX_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [SMX_DW-1:0] reg_rdata_o,
  output logic [SMX_CH*SMX_SW-1:0] aes_out_o,
  output logic [SMX_CH*SMX_SW-1:0] expansion_port_o,
  output logic out_valid_o
);
  smx_mem_if mem_if ();

  smx_slot_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .port(mem_if.mem)
  );

  function automatic logic peak_hit(input logic [SMX_AW-1:0] a);
    peak_hit = (a[8:4] == SMX_REG_PEAK_BASE[8:4]);
  endfunction

  // settings
  logic high_rate_r;
  logic bank_sel_r;
  logic [SMX_GW-1:0] master_r;
  logic [SMX_CH-1:0] mute_r;
  logic [SMX_CH-1:0] dither_en_r;

  // word clock synchroniser
  logic wclk_s1_r;
  logic wclk_s2_r;
  logic wclk_s3_r;
  logic wclk_lvl_r;
  logic wclk_prev_r;
  logic frame_start;

  // frame engine
  smx_state_type state_r;
  logic [3:0] ch_r;
  logic [3:0] slot_r;
  logic rd_vld_r;
  logic signed [SMX_ACCW-1:0] acc_r;
  logic signed [SMX_SW-1:0] rec_r [SMX_CH];
  logic signed [SMX_SW-1:0] play_r [SMX_CH];
  logic [31:0] lfsr_r;

  // results
  logic signed [SMX_SW-1:0] out_r [SMX_CH];
  logic signed [SMX_SW-1:0] exp_r [SMX_CH];
  logic [SMX_SW-1:0] peak_r [SMX_CH];
  logic [SMX_CH-1:0] clip_r;
  logic done_r;
  logic out_valid_r;
  logic [SMX_DW-1:0] rdata_r;

  // combinational datapath
  logic [3:0] last_slot;
  logic signed [SMX_SW-1:0] src_sample;
  logic [31:0] gain_prod;
  logic signed [SMX_GW:0] eff_gain;
  logic signed [SMX_ACCW-1:0] weighted;
  logic signed [15:0] dith;
  logic signed [SMX_ACCW-1:0] dithered;
  logic signed [SMX_ACCW-1:0] scaled;
  logic signed [SMX_SW-1:0] sat_val;
  logic sat_hit;
  logic [SMX_SW-1:0] abs_val;
  logic ch_out;
  logic clip_rd;
  logic slot_wr;

  // three-stage sync, level accepted once stages two and three agree
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      wclk_s1_r <= 1'b0;
      wclk_s2_r <= 1'b0;
      wclk_s3_r <= 1'b0;
      wclk_lvl_r <= 1'b0;
      wclk_prev_r <= 1'b0;
    end
    else
    begin
      wclk_s1_r <= sample_clk_i;
      wclk_s2_r <= wclk_s1_r;
      wclk_s3_r <= wclk_s2_r;
      if (wclk_s2_r == wclk_s3_r)
      begin
        wclk_lvl_r <= wclk_s3_r;
      end
      wclk_prev_r <= wclk_lvl_r;
    end
  end

  assign frame_start = wclk_lvl_r & ~wclk_prev_r;

  // register writes
  assign slot_wr = reg_wr_i && reg_addr_i[8] && (reg_addr_i[3:0] <= SMX_LAST_SLOT);

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      high_rate_r <= 1'b0;
      bank_sel_r <= 1'b0;
      master_r <= SMX_MASTER_RST;
      mute_r <= '0;
      dither_en_r <= '0;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        SMX_REG_CTRL:
        begin
          high_rate_r <= reg_wdata_i[SMX_CTRL_HIGH_RATE_BIT];
          bank_sel_r <= reg_wdata_i[SMX_CTRL_BANK_BIT];
        end
        SMX_REG_MASTER: master_r <= reg_wdata_i[SMX_GW-1:0];
        SMX_REG_MUTE: mute_r <= reg_wdata_i[SMX_CH-1:0];
        SMX_REG_DITHER: dither_en_r <= reg_wdata_i[SMX_CH-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // slot table writes and frame reads
  assign mem_if.wr_en = slot_wr;
  assign mem_if.wr_addr = reg_addr_i[7:0];
  assign mem_if.wr_data = reg_wdata_i[SMX_MDW-1:0];
  assign mem_if.rd_en = (state_r == SMX_MIX);
  assign mem_if.rd_addr = {ch_r, slot_r};

  assign last_slot = high_rate_r ? SMX_LAST_SLOT_HR : SMX_LAST_SLOT;

  // capture both buses at frame start
  generate
    for (genvar c = 0; c < SMX_CH; c++)
    begin : g_cap
      always_ff @(posedge ref_clk_i)
      begin
        if (sys_rst_i)
        begin
          rec_r[c] <= '0;
          play_r[c] <= '0;
        end
        else if (frame_start && state_r == SMX_IDLE)
        begin
          rec_r[c] <= record_bus_i[c*SMX_SW +: SMX_SW];
          play_r[c] <= play_bus_i[c*SMX_SW +: SMX_SW];
        end
      end
    end
  endgenerate

  // frame sequencer: channel by channel, slot by slot
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= SMX_IDLE;
      ch_r <= '0;
      slot_r <= '0;
      rd_vld_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      rd_vld_r <= (state_r == SMX_MIX);
      done_r <= 1'b0;
      unique case (state_r)
        SMX_IDLE:
        begin
          ch_r <= '0;
          slot_r <= '0;
          if (frame_start)
          begin
            state_r <= SMX_MIX;
          end
        end
        SMX_MIX:
        begin
          slot_r <= slot_r + 4'h1;
          if (slot_r == last_slot)
          begin
            state_r <= SMX_DRAIN;
          end
        end
        SMX_DRAIN: state_r <= SMX_OUT;
        SMX_OUT:
        begin
          slot_r <= '0;
          ch_r <= ch_r + 4'h1;
          if (ch_r == 4'(SMX_CH - 1))
          begin
            state_r <= SMX_IDLE;
            done_r <= 1'b1;
          end
          else
          begin
            state_r <= SMX_MIX;
          end
        end
      endcase
    end
  end

  // source select and weighting
  always_comb
  begin
    if (mem_if.rd_data[SMX_SLOT_PLAY_BIT])
    begin
      src_sample = play_r[mem_if.rd_data[SMX_SLOT_SRC_LSB +: 4]];
    end
    else
    begin
      src_sample = rec_r[mem_if.rd_data[SMX_SLOT_SRC_LSB +: 4]];
    end
    gain_prod = mem_if.rd_data[SMX_SLOT_GAIN_LSB +: SMX_GW] * master_r;
    eff_gain = $signed({1'b0, gain_prod[31:16]});
    weighted = SMX_ACCW'(src_sample) * SMX_ACCW'(eff_gain);
  end

  // 40-bit accumulation, cleared before each channel
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      acc_r <= '0;
    end
    else if (state_r == SMX_IDLE || state_r == SMX_OUT)
    begin
      acc_r <= '0;
    end
    else if (rd_vld_r)
    begin
      acc_r <= acc_r + weighted;
    end
  end

  // two uniform slices summed give triangular dither
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      lfsr_r <= SMX_LFSR_SEED;
    end
    else
    begin
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ SMX_LFSR_TAPS) : (lfsr_r >> 1);
    end
  end

  // dither, truncation, saturation
  always_comb
  begin
    dith = $signed({3'h0, lfsr_r[12:0]} + {3'h0, lfsr_r[28:16]} - SMX_DITH_OFS);
    if (dither_en_r[ch_r])
    begin
      dithered = acc_r + 40'(dith);
    end
    else
    begin
      dithered = acc_r;
    end
    scaled = dithered >>> SMX_FRAC;
    sat_hit = 1'b0;
    if (scaled > SMX_SAT_MAX)
    begin
      sat_val = SMX_SAT_MAX[SMX_SW-1:0];
      sat_hit = 1'b1;
    end
    else if (scaled < SMX_SAT_MIN)
    begin
      sat_val = SMX_SAT_MIN[SMX_SW-1:0];
      sat_hit = 1'b1;
    end
    else
    begin
      sat_val = scaled[SMX_SW-1:0];
    end
    abs_val = sat_val[SMX_SW-1] ? (~sat_val + 24'h00_0001) : sat_val;
  end

  assign ch_out = (state_r == SMX_OUT);
  assign clip_rd = reg_rd_i && (reg_addr_i == SMX_REG_CLIP);

  // per-channel output, peak meter and expansion routing
  generate
    for (genvar c = 0; c < SMX_CH; c++)
    begin : g_out
      always_ff @(posedge ref_clk_i)
      begin
        if (sys_rst_i)
        begin
          out_r[c] <= '0;
        end
        else if (ch_out && ch_r == 4'(c))
        begin
          out_r[c] <= mute_r[c] ? '0 : sat_val;
        end
      end

      // meter sees the dithered value even when muted; new peak beats read clear
      always_ff @(posedge ref_clk_i)
      begin
        if (sys_rst_i)
        begin
          peak_r[c] <= '0;
        end
        else if (ch_out && ch_r == 4'(c) &&
          (abs_val > peak_r[c] || (reg_rd_i && reg_addr_i == SMX_REG_PEAK_BASE + 9'(c))))
        begin
          peak_r[c] <= abs_val;
        end
        else if (reg_rd_i && reg_addr_i == SMX_REG_PEAK_BASE + 9'(c))
        begin
          peak_r[c] <= '0;
        end
      end

      always_ff @(posedge ref_clk_i)
      begin
        if (sys_rst_i)
        begin
          exp_r[c] <= '0;
        end
        else if (bank_sel_r)
        begin
          exp_r[c] <= out_r[c ^ 8];
        end
        else
        begin
          exp_r[c] <= out_r[c];
        end
      end

      assign aes_out_o[c*SMX_SW +: SMX_SW] = out_r[c];
      assign expansion_port_o[c*SMX_SW +: SMX_SW] = exp_r[c];
    end
  endgenerate

  // sticky clip flags, a new clip wins over the read clear
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      clip_r <= '0;
    end
    else
    begin
      clip_r <= (clip_rd ? '0 : clip_r) | ((ch_out && sat_hit) ? (16'h0001 << ch_r) : '0);
    end
  end

  // frame valid once expansion copy has settled
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      out_valid_r <= 1'b0;
    end
    else
    begin
      out_valid_r <= done_r;
    end
  end

  assign out_valid_o = out_valid_r;

  // register reads, data in the following cycle only
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_r <= '0;
    end
    else if (reg_rd_i)
    begin
      if (peak_hit(reg_addr_i))
      begin
        rdata_r <= {8'h00, peak_r[reg_addr_i[3:0]]};
      end
      else
      begin
        unique case (reg_addr_i)
          SMX_REG_CTRL: rdata_r <= {30'h0, bank_sel_r, high_rate_r};
          SMX_REG_MASTER: rdata_r <= {16'h0000, master_r};
          SMX_REG_MUTE: rdata_r <= {16'h0000, mute_r};
          SMX_REG_DITHER: rdata_r <= {16'h0000, dither_en_r};
          SMX_REG_CLIP: rdata_r <= {16'h0000, clip_r};
          SMX_REG_STATUS: rdata_r <= {31'h0, (state_r != SMX_IDLE)};
          default: rdata_r <= '0;
        endcase
      end
    end
    else
    begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata_o = rdata_r;
endmodule // smx_submixer
`default_nettype wire

//--- rtl/smx_pkg.sv
// Purpose: shared constants and types of the output submixer
// Assumes: one 100 MHz clock, plain register port with word addresses
// Notes: gains are unsigned, 16'h8000 means unity
package smx_pkg;
  localparam int SMX_CH = 16;
  localparam int SMX_SLOTS = 10;
  localparam int SMX_SLOTS_HR = 4;
  localparam int SMX_SW = 24;
  localparam int SMX_ACCW = 40;
  localparam int SMX_GW = 16;
  localparam int SMX_FRAC = 14;
  localparam int SMX_AW = 9;
  localparam int SMX_DW = 32;
  localparam int SMX_MAW = 8;
  localparam int SMX_MDW = 21;
  localparam int SMX_MDEPTH = 256;

  // register word addresses
  localparam logic [8:0] SMX_REG_CTRL = 9'h000;
  localparam logic [8:0] SMX_REG_MASTER = 9'h001;
  localparam logic [8:0] SMX_REG_MUTE = 9'h002;
  localparam logic [8:0] SMX_REG_DITHER = 9'h003;
  localparam logic [8:0] SMX_REG_CLIP = 9'h004;
  localparam logic [8:0] SMX_REG_STATUS = 9'h005;
  localparam logic [8:0] SMX_REG_PEAK_BASE = 9'h010;
  localparam logic [8:0] SMX_REG_SLOT_BASE = 9'h100;

  // field positions
  localparam int SMX_CTRL_HIGH_RATE_BIT = 0;
  localparam int SMX_CTRL_BANK_BIT = 1;
  localparam int SMX_SLOT_PLAY_BIT = 20;
  localparam int SMX_SLOT_SRC_LSB = 16;
  localparam int SMX_SLOT_GAIN_LSB = 0;

  // reset values and dither constants
  localparam logic [15:0] SMX_MASTER_RST = 16'h8000;
  localparam logic [31:0] SMX_LFSR_SEED = 32'hace1_0001;
  localparam logic [31:0] SMX_LFSR_TAPS = 32'h8020_0003;
  localparam logic [15:0] SMX_DITH_OFS = 16'h1fff;

  // slot counts as counter limits
  localparam logic [3:0] SMX_LAST_SLOT = 4'h9;
  localparam logic [3:0] SMX_LAST_SLOT_HR = 4'h3;

  localparam logic signed [39:0] SMX_SAT_MAX = 40'sh00_007f_ffff;
  localparam logic signed [39:0] SMX_SAT_MIN = -40'sh00_0080_0000;

  typedef enum logic [1:0] {SMX_IDLE, SMX_MIX, SMX_DRAIN, SMX_OUT} smx_state_type;
endpackage

//--- rtl/smx_mem_if.sv
// Purpose: link between the mixer core and its slot memory
// Assumes: one write port, one registered read port
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface smx_mem_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [20:0] wr_data;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [20:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr,
    input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr,
    output rd_data);
endinterface
`default_nettype wire

//--- rtl/smx_slot_mem.sv
// Purpose: source select and volume per submixer input slot
// Assumes: read data one cycle after rd_en
// Notes: index is channel times sixteen plus slot
`timescale 1ns/1ps
`default_nettype none
module smx_slot_mem
  import smx_pkg::*;
(
  input wire logic ref_clk_i,
  smx_mem_if.mem port
);
  logic [SMX_MDW-1:0] mem_r [SMX_MDEPTH];
  logic [SMX_MDW-1:0] rd_data_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (port.wr_en)
    begin
      mem_r[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (port.rd_en)
    begin
      rd_data_r <= mem_r[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_r;
endmodule // smx_slot_mem
`default_nettype wire

//--- tb/smx_submixer_asserts.sv
// Purpose: port checks of the output submixer
// Assumes: registers are written between frames only
// Notes: shadows ctrl, master and mute from the register port
`timescale 1ns/1ps
`default_nettype none
module smx_submixer_asserts
  import smx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_clk_i,
  input wire logic [SMX_AW-1:0] reg_addr_i,
  input wire logic [SMX_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [SMX_DW-1:0] reg_rdata_o,
  input wire logic [SMX_CH*SMX_SW-1:0] aes_out_o,
  input wire logic [SMX_CH*SMX_SW-1:0] expansion_port_o,
  input wire logic out_valid_o
);
  logic [1:0] ctrl_r;
  logic [15:0] master_r;
  logic [15:0] mute_r;
  logic pin_r;
  logic [9:0] cnt_r;
  logic mute_bad;
  int lo;
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_r <= 2'h0;
      master_r <= SMX_MASTER_RST;
      mute_r <= 16'h0000;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == SMX_REG_CTRL) ctrl_r <= reg_wdata_i[1:0];
      if (reg_addr_i == SMX_REG_MASTER) master_r <= reg_wdata_i[15:0];
      if (reg_addr_i == SMX_REG_MUTE) mute_r <= reg_wdata_i[15:0];
    end
  end
  // cycles since the last word clock pin rising edge, held at 10'h3ff
  always_ff @(posedge ref_clk_i)
  begin
    pin_r <= sample_clk_i;
    if (sample_clk_i && !pin_r) cnt_r <= 10'h000;
    else if (cnt_r != 10'h3ff) cnt_r <= cnt_r + 10'h001;
  end
  always_comb
  begin
    mute_bad = 1'b0;
    for (int c = 0; c < SMX_CH; c++)
      if (mute_r[c] && aes_out_o[c*SMX_SW+:SMX_SW] != '0) mute_bad = 1'b1;
  end
  assign lo = ctrl_r[0] ? 99 : 195;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  AST_MASTER_READ: assert property (reg_rd_i && reg_addr_i == SMX_REG_MASTER
    |=> reg_rdata_o == {16'h0000, master_r}) else $error("master readback wrong");
  AST_NOREAD_ZERO: assert property (reg_rd_i && (reg_addr_i == 9'h006 || reg_addr_i[8])
    |=> reg_rdata_o == '0) else $error("unmapped or slot read not zero");
  AST_VALID_PULSE: assert property (out_valid_o |=> !out_valid_o)
    else $error("frame valid longer than one cycle");
  AST_OUT_HOLD: assert property (out_valid_o |=>
    ($stable(aes_out_o) && $stable(expansion_port_o)) [*3]) else $error("outputs moved");
  AST_EXP_ROUTE: assert property (out_valid_o |-> expansion_port_o ==
    (ctrl_r[1] ? {aes_out_o[191:0], aes_out_o[383:192]} : aes_out_o))
    else $error("expansion routing wrong");
  AST_MUTE_ZERO: assert property (out_valid_o |-> !mute_bad)
    else $error("muted channel not zero");
  AST_FRAME_TIME: assert property ($rose(out_valid_o) |-> cnt_r >= lo && cnt_r <= lo + 13)
    else $error("frame length off");
endmodule // smx_submixer_asserts
`default_nettype wire

//--- tb/smx_tx_model.sv
// Purpose: behavioural transmitter side, takes each finished frame
// Assumes: frame is final in the cycle of the valid pulse
// Notes: keeps the last frame of both output buses
`timescale 1ns/1ps
`default_nettype none
module smx_tx_model
  import smx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic valid_i,
  input wire logic [SMX_CH*SMX_SW-1:0] aes_i,
  input wire logic [SMX_CH*SMX_SW-1:0] exp_i,
  output logic [SMX_CH*SMX_SW-1:0] aes_o,
  output logic [SMX_CH*SMX_SW-1:0] exp_o
);
  always @(posedge ref_clk_i)
    if (valid_i)
    begin
      aes_o <= aes_i;
      exp_o <= exp_i;
    end
endmodule // smx_tx_model
`default_nettype wire

//--- tb/multichannel_output_submixer_tb.sv
// Purpose: register and frame tests of the output submixer
// Assumes: unity gains pass samples unchanged
// Notes: registers are only touched between frames
`timescale 1ns/1ps
`default_nettype none
module multichannel_output_submixer_tb;
  import smx_pkg::*;
  logic ref_clk, sys_rst, sample_clk, reg_wr, reg_rd, out_valid;
  logic [8:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [383:0] rec, ply, aes, exp_bus, m_aes, m_exp;
  int num_errors = 0;
  int compares = 0;
  smx_submixer smx_submixer_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
    .sample_clk_i(sample_clk), .record_bus_i(rec), .play_bus_i(ply), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .aes_out_o(aes), .expansion_port_o(exp_bus), .out_valid_o(out_valid));
  smx_tx_model smx_tx_model_i (.ref_clk_i(ref_clk), .valid_i(out_valid), .aes_i(aes),
    .exp_i(exp_bus), .aes_o(m_aes), .exp_o(m_exp));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic give_verdict();
    $display("counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [8:0] a, input logic [31:0] want);
    logic [31:0] d;
    rd(a, d);
    check(d, want);
  endtask
  task automatic slot(int c, int s, logic p, logic [3:0] src, logic [15:0] g);
    wr(SMX_REG_SLOT_BASE + 9'(c * 16 + s), {11'h000, p, src, g});
  endtask
  task automatic frame();
    int n;
    @(posedge ref_clk);
    sample_clk <= 1'b1;
    n = 0;
    while (n < 400 && out_valid !== 1'b1)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n == 400)
    begin
      num_errors++;
      $display("unexpected at %0t: no frame", $time);
      give_verdict();
    end
    @(posedge ref_clk);
    sample_clk <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] och(int c);
    return {8'h00, m_aes[c*24+:24]};
  endfunction
  function automatic logic [31:0] mix(int n);
    logic signed [39:0] acc;
    acc = '0;
    for (int s = 0; s < n; s++)
      acc += s[0] ? 40'($signed(ply[s*24+:24])) : 40'($signed(rec[s*24+:24]));
    return {8'h00, acc[23:0]};
  endfunction
  initial
  begin
    logic [31:0] d;
    sys_rst = 1'b1;
    sample_clk = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 32'h0000_0000;
    for (int c = 0; c < 16; c++)
    begin
      rec[c*24+:24] = 24'((c + 1) * 4096);
      ply[c*24+:24] = 24'(-(c + 1) * 256);
    end
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(SMX_REG_MASTER, 32'h0000_8000);
    rdc(SMX_REG_CTRL, 32'h0000_0000);
    rdc(SMX_REG_MUTE, 32'h0000_0000);
    rdc(9'h006, 32'h0000_0000);
    rdc(SMX_REG_SLOT_BASE, 32'h0000_0000);
    rdc(SMX_REG_DITHER, 32'h0000_0000);
    rdc(SMX_REG_STATUS, 32'h0000_0000);
    $display("test reset done");
    for (int c = 0; c < 16; c++)
      for (int s = 0; s < 10; s++)
        slot(c, s, c == 0 && s[0], 4'(c == 0 ? s : c), (c == 0 || s == 0) ? 16'h8000 : 16'h0000);
    frame();
    check(och(0), mix(10));
    for (int c = 1; c < 16; c++)
      check(och(c), {8'h00, rec[c*24+:24]});
    for (int c = 0; c < 16; c++)
      check({8'h00, m_exp[c*24+:24]}, och(c));
    $display("test mix done");
    wr(SMX_REG_CTRL, 32'h0000_0003);
    rdc(SMX_REG_CTRL, 32'h0000_0003);
    frame();
    check(och(0), mix(4));
    for (int c = 0; c < 16; c++)
      check({8'h00, m_exp[c*24+:24]}, och(c ^ 8));
    $display("test rate and bank done");
    wr(SMX_REG_CTRL, 32'h0000_0000);
    rd(SMX_REG_PEAK_BASE + 9'h002, d);
    wr(SMX_REG_MUTE, 32'h0000_0004);
    wr(SMX_REG_DITHER, 32'h0000_0008);
    rdc(SMX_REG_DITHER, 32'h0000_0008);
    slot(5, 1, 1'b0, 4'h5, 16'h8000);
    slot(6, 1, 1'b0, 4'h6, 16'h8000);
    rec[5*24+:24] <= 24'h700000;
    rec[6*24+:24] <= 24'h900000;
    frame();
    check(och(2), 32'h0000_0000);
    check(och(4), 32'h0000_5000);
    check(32'(och(3) == 32'h4000 || och(3) == 32'h3fff), 32'h1);
    check(och(5), 32'h007f_ffff);
    check(och(6), 32'h0080_0000);
    rdc(SMX_REG_CLIP, 32'h0000_0060);
    rdc(SMX_REG_CLIP, 32'h0000_0000);
    rdc(SMX_REG_PEAK_BASE + 9'h002, 32'h0000_3000);
    $display("test mute dither clip done");
    wr(SMX_REG_MUTE, 32'h0000_0000);
    wr(SMX_REG_DITHER, 32'h0000_0000);
    wr(SMX_REG_MASTER, 32'h0000_4000);
    rdc(SMX_REG_MASTER, 32'h0000_4000);
    frame();
    check(och(9), 32'h0000_5000);
    $display("test master done");
    give_verdict();
  end
endmodule // multichannel_output_submixer_tb
bind smx_submixer smx_submixer_asserts smx_submixer_asserts_i (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .sample_clk_i(sample_clk_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .aes_out_o(aes_out_o), .expansion_port_o(expansion_port_o),
  .out_valid_o(out_valid_o));
`default_nettype wire
